// *** design/sap_device.sv ***
// Converter end: framing, shutdown and power-up dummy tracking
`timescale 1ns/1ns
`default_nettype none
module sap_device
  import sap_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // Link
  sap_link_if.dev                       link,
  // Strap giving the arbitrary power-on mode
  input  wire logic                     powerOnShutdown,
  // Value to be converted, taken at select fall
  input  wire logic [sap_pkg::DATA_W-1:0] sampleIn,
  // Status and results
  output logic                          inShutdown,
  output logic                          powerPending,
  output logic [sap_pkg::DATA_W-1:0]    convData,
  output logic                          convValid,
  output logic                          convDummy,
  output logic                          rateErr
);
  import sap_pkg::*;

  logic [1:0]        csSync_q;
  logic [1:0]        sclkSync_q;
  logic              csPrev_q;
  logic              sclkPrev_q;
  logic              strapDone_q;
  sap_state_e        state_q;
  sap_state_e        state_d;
  logic [CNT_W-1:0]  edgeCnt_q;
  logic [CNT_W-1:0]  periodCnt_q;
  logic              seenFrame_q;
  logic [WORD_W-1:0] word_q;
  logic              sdo_q;
  logic              oe_q;
  logic              shutdown_q;
  logic              pending_q;
  logic [DATA_W-1:0] data_q;
  logic [DATA_W-1:0] convData_q;
  logic              convValid_q;
  logic              convDummy_q;
  logic              rateErr_q;

  wire               csLevel;
  wire               sclkLevel;
  wire               csFall;
  wire               csRise;
  wire               sclkFall;
  wire               frameOn;
  wire [CNT_W-1:0]   edgeNext;
  wire               lastEdge;
  wire               reachNormal;
  wire               goShutdown;
  wire               startDummy;
  wire [WORD_W-1:0]  loadWord;

  // Saturating increment for edge counters
  function automatic logic [CNT_W-1:0] satInc(
    input logic [CNT_W-1:0] v,
    input logic [CNT_W-1:0] lim
  );
    satInc = (v >= lim) ? lim : v + 5'h01;
  endfunction : satInc

  // Two-stage synchronisers on select and serial clock
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      csSync_q   <= 2'h3;
      sclkSync_q <= 2'h3;
      csPrev_q   <= 1'b1;
      sclkPrev_q <= 1'b1;
    end
    else
    begin
      csSync_q   <= {csSync_q[0], link.csN};
      sclkSync_q <= {sclkSync_q[0], link.sclk};
      csPrev_q   <= csSync_q[1];
      sclkPrev_q <= sclkSync_q[1];
    end
  end

  // Edge detection on the synchronised link levels
  assign csLevel   = csSync_q[1];
  assign sclkLevel = sclkSync_q[1];
  assign csFall    = csPrev_q & ~csLevel;
  assign csRise    = ~csPrev_q & csLevel;
  assign sclkFall  = sclkPrev_q & ~sclkLevel;
  assign frameOn   = (state_q == ST_FRAME);

  // Frame decode from the falling edge count
  assign edgeNext    = satInc(edgeCnt_q, FRAME_EDGES);
  assign lastEdge    = frameOn & sclkFall & (edgeNext == FRAME_EDGES);
  assign reachNormal = frameOn & sclkFall & (edgeNext == NORMAL_EDGE);
  assign goShutdown  = frameOn & csRise & (edgeCnt_q >= SHDN_FIRST)
                     & (edgeCnt_q < NORMAL_EDGE);
  // A frame begun in shutdown or with power-up pending is a dummy
  assign startDummy  = pending_q | shutdown_q;
  assign loadWord    = startDummy ? '0
                     : {PAD_ZEROS, sampleIn, PAD_ZEROS};

  // Next state of the frame sequencer
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
        if (csFall)
          state_d = ST_FRAME;
      ST_FRAME:
        if (csRise)
          state_d = ST_IDLE;
        else if (lastEdge)
          state_d = ST_TAIL;
      ST_TAIL:
        if (csRise)
          state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  // Sequencer state and falling edge count within the frame
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q   <= ST_IDLE;
      edgeCnt_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (csFall)
        edgeCnt_q <= '0;
      else if (frameOn && sclkFall)
        edgeCnt_q <= edgeNext;
    end
  end

  // Serial shifter: a zero at select fall, next bit each falling edge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      word_q <= '0;
      sdo_q  <= 1'b0;
      oe_q   <= 1'b0;
    end
    else if (state_q == ST_IDLE && csFall)
    begin
      word_q <= loadWord;
      sdo_q  <= loadWord[WORD_W-1];
      oe_q   <= 1'b1;
    end
    else if ((frameOn && csRise) || lastEdge)
    begin
      oe_q <= 1'b0;
    end
    else if (frameOn && sclkFall)
    begin
      word_q <= {word_q[WORD_W-2:0], 1'b0};
      sdo_q  <= word_q[WORD_W-2];
    end
  end

  // Operating mode, caught from the strap after reset release
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      strapDone_q <= 1'b0;
      shutdown_q  <= 1'b0;
    end
    else if (!strapDone_q)
    begin
      strapDone_q <= 1'b1;
      shutdown_q  <= powerOnShutdown;
    end
    else if (goShutdown)
      shutdown_q <= 1'b1;
    else if (reachNormal)
      shutdown_q <= 1'b0;
  end

  // Power-up pending: set at power-on and on leaving shutdown
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pending_q <= 1'b1;
      data_q    <= '0;
    end
    else if (state_q == ST_IDLE && csFall)
    begin
      pending_q <= startDummy;
      data_q    <= sampleIn;
    end
    else if (lastEdge)
      pending_q <= 1'b0;
  end

  // Conversion result pulses at the sixteenth falling edge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      convData_q  <= '0;
      convValid_q <= 1'b0;
      convDummy_q <= 1'b0;
    end
    else
    begin
      convValid_q <= lastEdge & ~pending_q;
      convDummy_q <= lastEdge & pending_q;
      if (lastEdge && !pending_q)
        convData_q <= data_q;
    end
  end

  // Throughput watch: frame starts closer than twenty clock periods
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      periodCnt_q <= '0;
      seenFrame_q <= 1'b0;
      rateErr_q   <= 1'b0;
    end
    else
    begin
      rateErr_q <= csFall & seenFrame_q
                 & (periodCnt_q < MIN_PERIODS);
      if (csFall)
      begin
        periodCnt_q <= '0;
        seenFrame_q <= 1'b1;
      end
      else if (sclkFall)
        periodCnt_q <= satInc(periodCnt_q, MIN_PERIODS);
    end
  end

  // Link and user-side outputs
  assign link.sdoOut  = sdo_q;
  assign link.sdoOe   = oe_q;
  assign inShutdown   = shutdown_q;
  assign powerPending = pending_q;
  assign convData     = convData_q;
  assign convValid    = convValid_q;
  assign convDummy    = convDummy_q;
  assign rateErr      = rateErr_q;
endmodule : sap_device
`default_nettype wire

// *** design/sap_host.sv ***
// Host end: clock divider, frame scheduling and result capture
`timescale 1ns/1ns
`default_nettype none
module sap_host
  import sap_pkg::*;
#(
  parameter int unsigned HALF = sap_pkg::SCLK_HALF
)
(
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // Link
  sap_link_if.host                      link,
  // Conversion request, taken while ready is high
  input  wire logic                     convReq,
  input  wire logic                     lowPower,
  input  wire logic                     shutdownReq,
  output logic                          ready,
  // Results
  output logic [sap_pkg::DATA_W-1:0]    resultData,
  output logic                          resultValid,
  output logic                          resultDummy,
  output logic                          initDone
);
  import sap_pkg::*;

  logic [7:0]        divCnt_q;
  logic              sclk_q;
  logic              csN_q;
  logic [1:0]        dataSync_q;
  sap_state_e        state_q;
  logic [CNT_W-1:0]  fallCnt_q;
  logic [CNT_W-1:0]  periodCnt_q;
  logic [CNT_W-1:0]  stopAt_q;
  logic [3:0]        gapCnt_q;
  logic [WORD_W-1:0] bits_q;
  logic              shut_q;
  logic              pend_q;
  logic              init_q;
  logic [DATA_W-1:0] resultData_q;
  logic              resultValid_q;
  logic              resultDummy_q;

  wire               tick;
  wire               riseNow;
  wire               fallNow;
  wire               startNow;
  wire               endNow;
  wire               gapDone;
  wire [CNT_W-1:0]   stopSel;
  wire [DATA_W-1:0]  dataPick;

  // Free-running serial clock divider
  assign tick    = (divCnt_q == 8'(HALF - 1));
  assign riseNow = tick & ~sclk_q;
  assign fallNow = tick & sclk_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      divCnt_q   <= '0;
      sclk_q     <= 1'b1;
      dataSync_q <= 2'h3;
    end
    else
    begin
      divCnt_q   <= tick ? '0 : divCnt_q + 8'h01;
      sclk_q     <= tick ? ~sclk_q : sclk_q;
      dataSync_q <= {dataSync_q[0], link.serialResultOut};
    end
  end

  // Frame start and end decode
  assign ready    = (state_q == ST_IDLE) & init_q;
  assign startNow = (state_q == ST_IDLE) & riseNow
                  & (init_q ? convReq : 1'b1);
  assign stopSel  = !init_q     ? FRAME_EDGES
                  : shutdownReq ? SHDN_STOP
                  : lowPower    ? EARLY_STOP
                  : FRAME_EDGES;
  assign endNow   = (state_q == ST_FRAME) & riseNow
                  & (fallCnt_q == stopAt_q);
  assign gapDone  = (gapCnt_q >= GAP_CYC)
                  & (periodCnt_q >= MIN_PERIODS);
  assign dataPick = (stopAt_q == EARLY_STOP) ? bits_q[DATA_W-1:0]
                  : bits_q[DATA_W+3:4];

  // Frame sequencer, select line and edge counters
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q     <= ST_IDLE;
      csN_q       <= 1'b1;
      fallCnt_q   <= '0;
      periodCnt_q <= '0;
      stopAt_q    <= FRAME_EDGES;
      gapCnt_q    <= '0;
      bits_q      <= '0;
    end
    else
    begin
      if (fallNow)
        periodCnt_q <= (periodCnt_q >= MIN_PERIODS) ? periodCnt_q
                     : periodCnt_q + 5'h01;
      unique case (state_q)
        ST_IDLE:
          if (startNow)
          begin
            state_q     <= ST_FRAME;
            csN_q       <= 1'b0;
            fallCnt_q   <= '0;
            periodCnt_q <= '0;
            stopAt_q    <= stopSel;
          end
        ST_FRAME:
          if (endNow)
          begin
            state_q  <= ST_TAIL;
            csN_q    <= 1'b1;
            gapCnt_q <= '0;
          end
          else if (fallNow)
          begin
            fallCnt_q <= fallCnt_q + 5'h01;
            bits_q    <= {bits_q[WORD_W-2:0], dataSync_q[1]};
          end
        ST_TAIL:
          if (gapDone)
            state_q <= ST_IDLE;
          else if (gapCnt_q < GAP_CYC)
            gapCnt_q <= gapCnt_q + 4'h1;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Dummy tracking and result delivery
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      shut_q        <= 1'b0;
      pend_q        <= 1'b1;
      init_q        <= 1'b0;
      resultData_q  <= '0;
      resultValid_q <= 1'b0;
      resultDummy_q <= 1'b0;
    end
    else
    begin
      resultValid_q <= endNow & ~pend_q & (stopAt_q != SHDN_STOP);
      resultDummy_q <= endNow & pend_q & (stopAt_q != SHDN_STOP);
      if (startNow)
        shut_q <= (stopSel == SHDN_STOP);
      if (endNow)
      begin
        init_q <= 1'b1;
        pend_q <= shut_q;
        if (!pend_q && !shut_q)
          resultData_q <= dataPick;
      end
    end
  end

  // Link and user-side outputs
  assign link.csN    = csN_q;
  assign link.sclk   = sclk_q;
  assign resultData  = resultData_q;
  assign resultValid = resultValid_q;
  assign resultDummy = resultDummy_q;
  assign initDone    = init_q;
endmodule : sap_host
`default_nettype wire

// *** design/sap_link_if.sv ***
// Three-wire link between host controller and converter
`timescale 1ns/1ns
`default_nettype none
interface sap_link_if;
  logic csN;
  logic sclk;
  logic sdoOut;
  logic sdoOe;
  logic serialResultOut;
  // Floating output line reads as a weak pull-up high
  assign serialResultOut = sdoOe ? sdoOut : 1'b1;
  modport dev (input csN, input sclk, output sdoOut, output sdoOe);
  modport host (output csN, output sclk, input serialResultOut);
endinterface : sap_link_if
`default_nettype wire

// *** design/sap_pkg.sv ***
// Shared constants and types for the serial converter link
package sap_pkg;
  // Frame layout and edge counts
  localparam int unsigned        WORD_W      = 16;
  localparam int unsigned        DATA_W      = 8;
  localparam int unsigned        CNT_W       = 5;
  localparam logic [CNT_W-1:0]   FRAME_EDGES = 5'h10;
  localparam logic [CNT_W-1:0]   SHDN_FIRST  = 5'h02;
  localparam logic [CNT_W-1:0]   NORMAL_EDGE = 5'h0A;
  localparam logic [CNT_W-1:0]   MIN_PERIODS = 5'h14;
  localparam logic [CNT_W-1:0]   EARLY_STOP  = 5'h0C;
  localparam logic [CNT_W-1:0]   SHDN_STOP   = 5'h05;
  localparam logic [3:0]         PAD_ZEROS   = 4'h0;
  // Quiet gap between frames, rounded up to whole clocks
  localparam int unsigned        CLK_NS      = 40;
  localparam int unsigned        GAP_NS      = 50;
  localparam int unsigned        GAP_CYC_I   = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0]         GAP_CYC     = GAP_CYC_I[3:0];
  // Serial clock half period in system clocks
  localparam int unsigned        SCLK_HALF   = 4;
  // Link state, Gray along idle, frame, tail
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FRAME = 2'b01,
    ST_TAIL  = 2'b11
  } sap_state_e;
endpackage : sap_pkg

// *** tb/sap_link_monitor.sv ***
// Assertion checker for the host-to-converter link
`timescale 1ns/1ns
`default_nettype none
module sap_link_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link signals
  input wire logic csN,
  input wire logic sclk,
  input wire logic sdoOut,
  input wire logic sdoOe,
  input wire logic serialResultOut
);
  logic [4:0] gapCnt_q;
  logic [4:0] frmCnt_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Serial clock falls since frame start, and inside the frame
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gapCnt_q <= 5'h1F;
      frmCnt_q <= 5'h00;
    end
    else if ($fell(csN))
    begin
      gapCnt_q <= 5'h00;
      frmCnt_q <= 5'h00;
    end
    else if ($fell(sclk))
    begin
      gapCnt_q <= gapCnt_q + {4'h0, gapCnt_q != 5'h1F};
      frmCnt_q <= frmCnt_q + {4'h0, !csN};
    end
  end
  // Framing, spacing and output checks
  a_oe_after_select: assert property ($fell(csN) |-> ##[1:6] sdoOe)
    else $error("output not enabled after select fall");
  a_lead_zero: assert property ($rose(sdoOe) |-> !sdoOut && !csN)
    else $error("frame does not open with a zero");
  a_frame_spacing: assert property ($fell(csN) |-> gapCnt_q >= 5'h14)
    else $error("frames closer than twenty clock periods");
  a_quiet_gap: assert property ($rose(csN) |=> csN)
    else $error("select high for under two clocks");
  a_float_on_rise: assert property ($rose(csN) |-> ##[0:5] !sdoOe)
    else $error("output still driven after select rise");
  a_sixteen_falls: assert property ($fell(sdoOe) |->
    frmCnt_q == 5'h10 || csN)
    else $error("output released before sixteenth fall");
  a_end_edge_legal: assert property ($rose(csN) |->
    frmCnt_q inside {5'h05, 5'h0C, 5'h10})
    else $error("frame ended at an unplanned edge");
  a_pad_zeros: assert property ($fell(sclk) && sdoOe &&
    (frmCnt_q < 5'h04 || frmCnt_q > 5'h0B) |-> !sdoOut)
    else $error("pad bit not zero");
  a_sclk_divider: assert property ($changed(sclk) |=>
    $stable(sclk)[*3] ##1 $changed(sclk))
    else $error("serial clock half period wrong");
  a_idle_float: assert property (csN && $past(csN, 5) |->
    !sdoOe && serialResultOut)
    else $error("result line driven while select idles high");
  // Main frame kinds
  c_shutdown_end: cover property ($rose(csN) && frmCnt_q == 5'h05);
  c_early_end: cover property ($rose(csN) && frmCnt_q == 5'h0C);
  c_full_end: cover property ($rose(csN) && frmCnt_q == 5'h10);
endmodule : sap_link_monitor
`default_nettype wire

// *** tb/serial_adc_power_sequencer_tb_top.sv ***
// Bench: joined host and converter, plus a bench-driven converter
`timescale 1ns/1ns
`default_nettype none
module serial_adc_power_sequencer_tb_top;
  import sap_pkg::*;
  // Stimulus
  logic        clk = 1'h0;
  logic        resetn = 1'h0;
  logic        convReq = 1'h0;
  logic        lowPower = 1'h0;
  logic        shutdownReq = 1'h0;
  logic [7:0]  sampleIn = 8'h00;
  logic [7:0]  sampleB = 8'h00;
  // Design outputs
  logic        ready, initDone, resultValid, resultDummy;
  logic        inShutdown, powerPending, shdB, pendB;
  logic        validB, dummyB, rateB;
  logic [7:0]  resultData, dataB;
  // Pulse catchers and counters
  logic        vA = 1'h0, dA = 1'h0, vB = 1'h0, dB = 1'h0, rB = 1'h0;
  logic [15:0] word;
  int          errors = 0;
  int          checksDone = 0;
  int          cycles = 0;
  sap_link_if lnk ();
  sap_link_if lnkB ();
  sap_host #(.HALF(4)) i_sap_host (
    .clk(clk), .resetn(resetn), .link(lnk.host), .convReq(convReq),
    .lowPower(lowPower), .shutdownReq(shutdownReq), .ready(ready),
    .resultData(resultData), .resultValid(resultValid),
    .resultDummy(resultDummy), .initDone(initDone));
  sap_device i_sap_device (
    .clk(clk), .resetn(resetn), .link(lnk.dev), .powerOnShutdown(1'h0),
    .sampleIn(sampleIn), .inShutdown(inShutdown),
    .powerPending(powerPending), .convData(), .convValid(),
    .convDummy(), .rateErr());
  sap_device i_sap_device_b (
    .clk(clk), .resetn(resetn), .link(lnkB.dev), .powerOnShutdown(1'h1),
    .sampleIn(sampleB), .inShutdown(shdB), .powerPending(pendB),
    .convData(dataB), .convValid(validB), .convDummy(dummyB),
    .rateErr(rateB));
  sap_link_monitor i_sap_link_monitor (
    .clk(clk), .resetn(resetn), .csN(lnk.csN), .sclk(lnk.sclk),
    .sdoOut(lnk.sdoOut), .sdoOe(lnk.sdoOe),
    .serialResultOut(lnk.serialResultOut));
  // System clock
  always #20 clk = ~clk;
  task automatic wrap_up;
    $display("checks %0d errors %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      errors++;
      $display("BAD timeout exp 0 got %0d", cycles);
      wrap_up;
    end
  end
  task automatic chkf(input string nm, input logic e, input logic g);
    checksDone++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask : chkf
  task automatic chkw(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
    checksDone++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chkw
  // Wait clocks, catching one-clock pulses
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      #2;
      vA |= resultValid;
      dA |= resultDummy;
      vB |= validB;
      dB |= dummyB;
      rB |= rateB;
    end
  endtask : tick
  task automatic clr;
    {vA, dA, vB, dB, rB} = 5'h00;
  endtask : clr
  task automatic waitRdy(input logic v);
    int n;
    n = 0;
    while (ready !== v && n < 800)
    begin
      tick(1);
      n++;
    end
    if (ready !== v)
    begin
      errors++;
      $display("BAD ready exp %b got %b", v, ready);
    end
  endtask : waitRdy
  // One request through the host end
  task automatic conv(input logic lp, input logic sd, input logic [7:0] d);
    waitRdy(1'h1);
    clr;
    sampleIn = d;
    lowPower = lp;
    shutdownReq = sd;
    convReq = 1'h1;
    waitRdy(1'h0);
    convReq = 1'h0;
    waitRdy(1'h1);
  endtask : conv
  task automatic expA(input logic v, input logic m, input logic [7:0] x);
    chkf("resultValid", v, vA);
    chkf("resultDummy", m, dA);
    if (v)
      chkw("resultData", {8'h00, x}, {8'h00, resultData});
  endtask : expA
  // One 320 ns serial clock period on the bench link
  task automatic sck(input bit s);
    tick(4);
    if (s)
      word = {word[14:0], lnkB.serialResultOut};
    lnkB.sclk = 1'h0;
    tick(4);
    lnkB.sclk = 1'h1;
  endtask : sck
  // Frame of n falls; short leaves no spacing clocks after it
  task automatic frm(input int n, input bit sh, input logic [7:0] d);
    sampleB = d;
    word = 16'h0000;
    clr;
    lnkB.csN = 1'h0;
    tick(4);
    repeat (n)
      sck(1'h1);
    lnkB.csN = 1'h1;
    tick(6);
    chkf("sdoOeB", 1'h0, lnkB.sdoOe);
    repeat (sh ? 0 : 20 - n)
      sck(1'h0);
  endtask : frm
  task automatic expB(input logic v, input logic m);
    chkf("convValidB", v, vB);
    chkf("convDummyB", m, dB);
    chkf("rateErrB", 1'h0, rB);
  endtask : expB
  // Main sequence
  initial
  begin
    lnkB.csN = 1'h1;
    lnkB.sclk = 1'h1;
    tick(3);
    resetn = 1'h1;
    tick(2);
    chkf("inShutdownB", 1'h1, shdB);
    chkf("powerPendingB", 1'h1, pendB);
    waitRdy(1'h1);
    chkf("initDone", 1'h1, initDone);
    chkf("resultDummy", 1'h1, dA);
    chkf("powerPending", 1'h0, powerPending);
    conv(1'h0, 1'h0, 8'hA5);
    expA(1'h1, 1'h0, 8'hA5);
    conv(1'h0, 1'h0, 8'h3C);
    expA(1'h1, 1'h0, 8'h3C);
    conv(1'h0, 1'h1, 8'h00);
    chkf("inShutdown", 1'h1, inShutdown);
    conv(1'h0, 1'h0, 8'h5A);
    expA(1'h0, 1'h1, 8'h00);
    conv(1'h0, 1'h0, 8'h81);
    expA(1'h1, 1'h0, 8'h81);
    conv(1'h1, 1'h0, 8'hC6);
    chkf("inShutdown", 1'h0, inShutdown);
    expA(1'h1, 1'h0, 8'hC6);
    conv(1'h0, 1'h0, 8'h7E);
    expA(1'h1, 1'h0, 8'h7E);
    frm(16, 1'h0, 8'hC3);
    expB(1'h0, 1'h1);
    chkw("wordB", 16'h0000, word);
    chkf("powerPendingB", 1'h0, pendB);
    frm(16, 1'h0, 8'hC3);
    expB(1'h1, 1'h0);
    chkw("wordB", 16'h0C30, word);
    chkw("convDataB", 16'h00C3, {8'h00, dataB});
    frm(1, 1'h0, 8'h00);
    chkf("inShutdownB", 1'h0, shdB);
    frm(10, 1'h0, 8'h00);
    expB(1'h0, 1'h0);
    chkf("inShutdownB", 1'h0, shdB);
    frm(15, 1'h0, 8'h00);
    chkf("inShutdownB", 1'h0, shdB);
    frm(2, 1'h0, 8'h00);
    expB(1'h0, 1'h0);
    chkf("inShutdownB", 1'h1, shdB);
    frm(16, 1'h0, 8'h96);
    expB(1'h0, 1'h1);
    frm(9, 1'h0, 8'h00);
    chkf("inShutdownB", 1'h1, shdB);
    frm(1, 1'h0, 8'h00);
    chkf("inShutdownB", 1'h1, shdB);
    frm(16, 1'h0, 8'h00);
    expB(1'h0, 1'h1);
    frm(16, 1'h1, 8'h5A);
    expB(1'h1, 1'h0);
    chkw("convDataB", 16'h005A, {8'h00, dataB});
    frm(16, 1'h0, 8'h5A);
    chkf("rateErrB", 1'h1, rB);
    wrap_up;
  end
endmodule : serial_adc_power_sequencer_tb_top
`default_nettype wire
